// *** core/ppw_defs.vh ***
// Register map, field positions, reset values and timing constants of the capture timer
`ifndef PPW_DEFS_VH
`define PPW_DEFS_VH
`define PPW_OFF_START      12'h000
`define PPW_OFF_MODE       12'h004
`define PPW_OFF_VALUE      12'h008
`define PPW_OFF_PRESCALE   12'h00C
`define PPW_OFF_IRQ_STATUS 12'h010
`define PPW_OFF_IRQ_MASK   12'h014
`define PPW_OFF_COUNT      12'h018
`define PPW_START_RUN      0
`define PPW_MODE_EDGE      0
`define PPW_MODE_MEAS      1
`define PPW_MODE_OVF       3
`define PPW_MODE_SRC_LO    6
`define PPW_MODE_SRC_HI    7
`define PPW_IRQ_EDGE       0
`define PPW_IRQ_OVF        1
`define PPW_SRC_UNDIV      2'b00
`define PPW_SRC_DIV8       2'b01
`define PPW_SRC_PRESCALED  2'b10
`define PPW_SRC_SUB32      2'b11
`define PPW_DIV8_LAST      3'h7
`define PPW_SUB32_LAST     5'h1F
`define PPW_RESP_OKAY      2'b00
`define PPW_RESP_SLVERR    2'b10
`define PPW_MODE_RESET     8'h00
`define PPW_COUNT_MAX      16'hFFFF
`endif

// *** core/ppw_timer.v ***
// Pulse period and pulse width capture timer with AXI4-Lite registers
//
// Summary of operation
// - Count source: undivided, div8, prescaled, subclock div32
// - Counter increments each source tick while running
// - Valid edge captures count, then clears counter
// - Run bit starts and stops counting
// - Interrupt on valid edge and overflow
// - Overflow flag set with overflow interrupt
// - Mode write while running clears flag after running tick
// - Pin serves only as measured pulse input
// - Value register reads last captured result
// - Value register writes are ignored
// - First valid edge after start raises nothing
`timescale 1ns/100ps
`include "ppw_defs.vh"
module ppw_timer (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        subclock,
  input  wire        measured_pulse_pin,
  output wire        irq
);
  reg         aw_held;
  reg  [11:0] aw_addr;
  reg         w_held;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  reg         timer_run_bit;
  reg  [7:0]  timer_mode_register;
  reg  [3:0]  prescale_divider_field;
  reg  [1:0]  irq_status;
  reg  [1:0]  irq_mask;
  reg  [15:0] counter;
  reg  [15:0] reload;
  reg  [2:0]  div8_cnt;
  reg  [3:0]  pre_cnt;
  reg         pre_half;
  reg  [4:0]  sub_cnt;
  reg         sub_q;
  reg         pin_q;
  reg         first_edge;
  reg         ovf_armed;
  wire [1:0]  next_irq_status;
  reg         tick;
  reg         valid_edge;
  wire        wr_fire;
  wire        rd_fire;
  wire        ovf_event;
  wire        edge_event;
  wire        wr_mode;
  wire        pin_rise;
  wire        pin_fall;
  wire [1:0]  src_sel;
  wire        wr_start;
  wire        wr_prescale;
  wire        wr_clear;
  wire        wr_mask;
  wire        wr_mapped;
  wire        tick_div8;
  wire        tick_pre;
  wire        tick_sub;
  wire [1:0]  irq_event;
  reg  [31:0] next_rdata;
  reg  [1:0]  next_rresp;
  genvar      gi;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
  assign rd_fire       = s_axi_arvalid && !s_axi_rvalid;
  assign wr_mode       = wr_fire && (aw_addr == `PPW_OFF_MODE) && w_strb[0];
  assign src_sel       = timer_mode_register[`PPW_MODE_SRC_HI:`PPW_MODE_SRC_LO];
  assign pin_rise      = measured_pulse_pin && !pin_q;
  assign pin_fall      = !measured_pulse_pin && pin_q;
  assign wr_start      = wr_fire && (aw_addr == `PPW_OFF_START) && w_strb[0];
  assign wr_prescale   = wr_fire && (aw_addr == `PPW_OFF_PRESCALE) && w_strb[0];
  assign wr_clear      = wr_fire && (aw_addr == `PPW_OFF_IRQ_STATUS) && w_strb[0];
  assign wr_mask       = wr_fire && (aw_addr == `PPW_OFF_IRQ_MASK) && w_strb[0];
  assign wr_mapped     = (aw_addr == `PPW_OFF_START) || (aw_addr == `PPW_OFF_MODE) ||
                         (aw_addr == `PPW_OFF_VALUE) || (aw_addr == `PPW_OFF_PRESCALE) ||
                         (aw_addr == `PPW_OFF_IRQ_STATUS) || (aw_addr == `PPW_OFF_IRQ_MASK) ||
                         (aw_addr == `PPW_OFF_COUNT);

  // Ticks of the divided sources
  assign tick_div8 = (div8_cnt == `PPW_DIV8_LAST);
  assign tick_pre  = (prescale_divider_field == 4'h0) ||
                     (pre_half && (pre_cnt == prescale_divider_field - 4'h1));
  assign tick_sub  = subclock && !sub_q && (sub_cnt == `PPW_SUB32_LAST);

  // Count source selection
  always @* begin
    case (src_sel)
      `PPW_SRC_UNDIV:     tick = 1'b1;
      `PPW_SRC_DIV8:      tick = tick_div8;
      `PPW_SRC_PRESCALED: tick = tick_pre;
      default:            tick = tick_sub;
    endcase
  end

  // Period: like edges; width: both edges
  always @* begin
    if (timer_mode_register[`PPW_MODE_MEAS]) begin
      valid_edge = pin_rise || pin_fall;
    end else if (timer_mode_register[`PPW_MODE_EDGE]) begin
      valid_edge = pin_rise;
    end else begin
      valid_edge = pin_fall;
    end
  end

  assign edge_event = timer_run_bit && valid_edge;
  assign ovf_event  = timer_run_bit && tick && !edge_event && (counter == `PPW_COUNT_MAX);

  // Divide-by-eight count source
  always @(posedge aclk) begin
    if (!aresetn) begin
      div8_cnt <= 3'h0;
    end else begin
      div8_cnt <= div8_cnt + 3'h1;
    end
  end

  // Prescaler, half period of n clocks
  always @(posedge aclk) begin
    if (!aresetn) begin
      pre_cnt  <= 4'h0;
      pre_half <= 1'b0;
    end else if (prescale_divider_field == 4'h0 || pre_cnt == prescale_divider_field - 4'h1) begin
      pre_cnt  <= 4'h0;
      pre_half <= !pre_half;
    end else begin
      pre_cnt <= pre_cnt + 4'h1;
    end
  end

  // Subclock rising edges, 32 to a tick
  always @(posedge aclk) begin
    if (!aresetn) begin
      sub_q   <= 1'b0;
      sub_cnt <= 5'h00;
    end else begin
      sub_q <= subclock;
      if (subclock && !sub_q) begin
        sub_cnt <= sub_cnt + 5'h01;
      end
    end
  end

  // Previous pin level for edge detection
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= measured_pulse_pin;
    end
  end

  // Live counter, cleared on a valid edge
  always @(posedge aclk) begin
    if (!aresetn) begin
      counter <= 16'h0000;
    end else if (edge_event) begin
      counter <= 16'h0000;
    end else if (timer_run_bit && tick) begin
      counter <= counter + 16'h0001;
    end
  end

  // Capture register holds the last measurement
  always @(posedge aclk) begin
    if (!aresetn) begin
      reload <= 16'h0000;
    end else if (edge_event) begin
      reload <= counter;
    end
  end

  // First edge after start raises no request
  always @(posedge aclk) begin
    if (!aresetn) begin
      first_edge <= 1'b1;
    end else if (!timer_run_bit) begin
      first_edge <= 1'b1;
    end else if (edge_event) begin
      first_edge <= 1'b0;
    end
  end

  assign irq_event[`PPW_IRQ_EDGE] = edge_event && !first_edge;
  assign irq_event[`PPW_IRQ_OVF]  = ovf_event;

  // Sticky status bits, write one to clear, set wins
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_irq_bit
      assign next_irq_status[gi] = irq_event[gi] || (irq_status[gi] && !(wr_clear && w_data[gi]));
    end
  endgenerate

  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= 2'b00;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // Write address holding
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
  end

  // Write data holding
  always @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
  end

  // Write response, unmapped offsets answer with an error
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PPW_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? `PPW_RESP_OKAY : `PPW_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      timer_run_bit <= 1'b0;
    end else if (wr_start) begin
      timer_run_bit <= w_data[`PPW_START_RUN];
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      prescale_divider_field <= 4'h0;
    end else if (wr_prescale) begin
      prescale_divider_field <= w_data[3:0];
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask <= 2'b00;
    end else if (wr_mask) begin
      irq_mask <= w_data[1:0];
    end
  end

  // Overflow clear needs a running tick after the set
  always @(posedge aclk) begin
    if (!aresetn) begin
      ovf_armed <= 1'b0;
    end else if (ovf_event) begin
      ovf_armed <= 1'b0;
    end else if (timer_run_bit && tick) begin
      ovf_armed <= 1'b1;
    end
  end

  // Mode register, overflow flag set wins
  always @(posedge aclk) begin
    if (!aresetn) begin
      timer_mode_register <= `PPW_MODE_RESET;
    end else begin
      if (wr_mode) begin
        timer_mode_register[`PPW_MODE_SRC_HI:`PPW_MODE_SRC_LO] <= w_data[`PPW_MODE_SRC_HI:`PPW_MODE_SRC_LO];
        timer_mode_register[`PPW_MODE_MEAS] <= w_data[`PPW_MODE_MEAS];
        timer_mode_register[`PPW_MODE_EDGE] <= w_data[`PPW_MODE_EDGE];
      end
      if (ovf_event) begin
        timer_mode_register[`PPW_MODE_OVF] <= 1'b1;
      end else if (wr_mode && timer_run_bit && ovf_armed) begin
        timer_mode_register[`PPW_MODE_OVF] <= 1'b0;
      end
    end
  end

  // Read data selection
  always @* begin
    next_rresp = `PPW_RESP_OKAY;
    case (s_axi_araddr)
      `PPW_OFF_START:      next_rdata = {31'h0000_0000, timer_run_bit};
      `PPW_OFF_MODE:       next_rdata = {24'h00_0000, timer_mode_register};
      `PPW_OFF_VALUE:      next_rdata = {16'h0000, reload};
      `PPW_OFF_PRESCALE:   next_rdata = {28'h000_0000, prescale_divider_field};
      `PPW_OFF_IRQ_STATUS: next_rdata = {30'h0000_0000, irq_status};
      `PPW_OFF_IRQ_MASK:   next_rdata = {30'h0000_0000, irq_mask};
      `PPW_OFF_COUNT:      next_rdata = {16'h0000, counter};
      default: begin
        next_rdata = 32'h0000_0000;
        next_rresp = `PPW_RESP_SLVERR;
      end
    endcase
  end

  // Read answer register
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `PPW_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // ppw_timer

// *** testbench/ppw_pulse_src.sv ***
// Pulse source model for the measured input
`timescale 1ns/100ps
module ppw_pulse_src (
  input  wire       aclk,
  input  wire       en,
  input  wire [7:0] per,
  output reg        pin
);
  reg [7:0] cnt = 8'h00;
  initial pin = 1'b0;
  // Square wave of per cycles, only the measured pulse
  always @(posedge aclk) begin
    cnt <= (!en || cnt == per - 8'h01) ? 8'h00 : cnt + 8'h01;
    pin <= en && (cnt < {1'b0, per[7:1]});
  end
endmodule // ppw_pulse_src

// *** testbench/ppw_timer_monitor.sv ***
// Bus and interrupt checker of the capture timer
`timescale 1ns/100ps
module ppw_timer_monitor (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rd_req; s_axi_arvalid && !s_axi_rvalid; endsequence
  sequence s_rd_end; s_axi_rvalid && s_axi_rready; endsequence
  sequence s_wr_end; s_axi_bvalid && s_axi_bready; endsequence
  AST_RD_LAT: assert property (s_rd_req |=> s_axi_rvalid) else $error("Read answer late");
  AST_RD_DONE: assert property (s_rd_end |=> !s_axi_rvalid) else $error("Read answer held");
  AST_RD_IDLE: assert property (!s_axi_arvalid && !s_axi_rvalid |=> !s_axi_rvalid) else $error("Stray read");
  AST_AR_BLK: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("Read taken while busy");
  AST_WR_DONE: assert property (s_wr_end |=> !s_axi_bvalid) else $error("Write answer held");
  AST_AW_BLK: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("Address taken while busy");
  AST_W_BLK: assert property (s_axi_bvalid |-> !s_axi_wready) else $error("Data taken while busy");
  AST_IRQ_RST: assert property ($rose(aresetn) |-> !irq) else $error("Interrupt after reset");
endmodule // ppw_timer_monitor
bind ppw_timer ppw_timer_monitor u_mon (.aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .irq);

// *** testbench/tb.sv ***
// Self-checking bench of the capture timer
`timescale 1ns/100ps
`include "ppw_defs.vh"
module tb;
  reg         aclk = 1'b0;
  reg         aresetn = 1'b0;
  reg  [11:0] awaddr = 12'h000;
  reg  [11:0] araddr = 12'h000;
  reg  [31:0] wdata = 32'h0000_0000;
  reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, en = 1'b0;
  reg  [7:0]  per = 8'h14;
  reg  [7:0]  md;
  reg         sub = 1'b0;
  reg  [1:0]  eb;
  reg  [1:0]  wq[$];
  wire        awready, wready, bvalid, arready, rvalid, irq, pin;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  integer     error_cnt = 0, samples_checked = 0, i, m;
  reg  [45:0] q[$];
  reg  [45:0] e;
  ppw_timer u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .subclock(sub),
    .measured_pulse_pin(pin), .irq(irq));
  ppw_pulse_src u_src (.aclk(aclk), .en(en), .per(per), .pin(pin));
  initial forever #50 aclk = ~aclk;
  always @(posedge aclk) sub <= ~sub;
  task chk(input [33:0] s, input [33:0] x, input [11:0] n);
    samples_checked = samples_checked + 1;
    if (s !== x) begin
      error_cnt = error_cnt + 1;
      $display("ERROR at %h expected %h seen %h", n, x, s);
    end
  endtask
  task print_verdict;
    $display("checked %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task wr(input [11:0] a, input [31:0] d);
    wq.push_back((a <= `PPW_OFF_COUNT && a[1:0] == 2'b00) ? `PPW_RESP_OKAY : `PPW_RESP_SLVERR);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50 && !(bvalid && !awvalid && !wvalid); i = i + 1) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (i == 50) begin error_cnt = error_cnt + 1; print_verdict; end
  endtask
  task rd(input [11:0] a, input [33:0] x);
    q.push_back({a, x});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50 && !(rvalid && !arvalid); i = i + 1) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (i == 50) begin error_cnt = error_cnt + 1; print_verdict; end
  endtask
  always @(posedge aclk) if (bvalid && bready) begin
    eb = wq.pop_front();
    chk({32'h0, bresp}, {32'h0, eb}, 12'hBBB);
  end
  always @(posedge aclk) if (rvalid && rready) begin
    e = q.pop_front();
    chk({rresp, rdata}, e[33:0], e[45:34]);
  end
  initial begin
    i = $urandom(32'h9ef0d057);
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`PPW_OFF_MODE, 34'h0);
    rd(`PPW_OFF_IRQ_MASK, 34'h0);
    rd(12'h020, {`PPW_RESP_SLVERR, 32'h0000_0000});
    wr(12'h024, 32'h0000_0000);
    wr(`PPW_OFF_MODE, 32'h0000_0040);
    wr(`PPW_OFF_START, 32'h0000_0001);
    repeat (60) @(posedge aclk);
    wr(`PPW_OFF_START, 32'h0000_0000);
    rd(`PPW_OFF_COUNT, 34'h8);
    wr(`PPW_OFF_PRESCALE, 32'h0000_0002);
    wr(`PPW_OFF_MODE, 32'h0000_0080);
    wr(`PPW_OFF_START, 32'h0000_0001);
    repeat (60) @(posedge aclk);
    wr(`PPW_OFF_START, 32'h0000_0000);
    rd(`PPW_OFF_COUNT, 34'h18);
    wr(`PPW_OFF_MODE, 32'h0000_00C0);
    wr(`PPW_OFF_START, 32'h0000_0001);
    repeat (60) @(posedge aclk);
    wr(`PPW_OFF_START, 32'h0000_0000);
    rd(`PPW_OFF_COUNT, 34'h19);
    $display("test count sources done");
    $display("test reset done");
    for (m = 0; m < 4; m = m + 1) begin
      md = (m == 0) ? 8'h01 : (m == 1) ? 8'h00 : (m == 2) ? 8'h02 : 8'h81;
      en <= 1'b0;
      per <= 8'h14 + {2'h0, 5'($urandom % 20), 1'b0};
      wr(`PPW_OFF_START, 32'h0000_0000);
      wr(`PPW_OFF_PRESCALE, 32'h0000_0000);
      wr(`PPW_OFF_IRQ_STATUS, 32'h0000_0003);
      rd(`PPW_OFF_IRQ_STATUS, 34'h0);
      wr(`PPW_OFF_IRQ_MASK, 32'h0000_0001);
      wr(`PPW_OFF_MODE, {24'h0, md});
      wr(`PPW_OFF_START, 32'h0000_0001);
      en <= 1'b1;
      repeat (per / 4) @(posedge aclk);
      rd(`PPW_OFF_IRQ_STATUS, 34'h0);
      repeat (3 * per) @(posedge aclk);
      rd(`PPW_OFF_VALUE, (m == 2) ? per / 2 - 1 : per - 1);
      rd(`PPW_OFF_IRQ_STATUS, 34'h1);
      chk({33'h0, irq}, 34'h1, 12'hFFF);
      wr(`PPW_OFF_VALUE, 32'h0000_1234);
      rd(`PPW_OFF_VALUE, (m == 2) ? per / 2 - 1 : per - 1);
      wr(`PPW_OFF_IRQ_MASK, 32'h0000_0000);
      chk({33'h0, irq}, 34'h0, 12'hFFF);
      $display("test mode %h done", md);
    end
    en <= 1'b0;
    wr(`PPW_OFF_START, 32'h0000_0000);
    wr(`PPW_OFF_IRQ_STATUS, 32'h0000_0003);
    wr(`PPW_OFF_IRQ_MASK, 32'h0000_0002);
    wr(`PPW_OFF_MODE, 32'h0000_0001);
    wr(`PPW_OFF_START, 32'h0000_0001);
    for (i = 0; i < 70000 && irq !== 1'b1; i = i + 1) @(posedge aclk);
    if (i == 70000) begin error_cnt = error_cnt + 1; print_verdict; end
    rd(`PPW_OFF_MODE, 34'h9);
    rd(`PPW_OFF_IRQ_STATUS, 34'h2);
    wr(`PPW_OFF_START, 32'h0000_0000);
    wr(`PPW_OFF_MODE, 32'h0000_0001);
    rd(`PPW_OFF_MODE, 34'h9);
    wr(`PPW_OFF_START, 32'h0000_0001);
    wr(`PPW_OFF_MODE, 32'h0000_0001);
    rd(`PPW_OFF_MODE, 34'h1);
    $display("test overflow done");
    print_verdict;
  end
endmodule // tb
